// [logic/lcm_params.svh]
// constants for the control-mode pin decoder and its small register file
// assumes inclusion by bare name from the design file
`ifndef LCM_PARAMS_SVH
`define LCM_PARAMS_SVH
`define LCM_OFS_MASK_FIRST 6'h13
`define LCM_OFS_MASK_SECOND 6'h14
`define LCM_OFS_STAT_FIRST 6'h18
`define LCM_OFS_STAT_SECOND 6'h19
`define LCM_OFS_GLOBAL_CFG 6'h20
`define LCM_CFG_BIT_GMASK 0
`define LCM_CFG_BIT_IRQ_POL 1
`define LCM_CFG_RESET 8'h01
`define LCM_MASK_RESET 8'hFF
`define LCM_STAT_RESET 8'h00
`define LCM_MODE_HW 2'h0
`define LCM_MODE_SERIAL 2'h1
`define LCM_MODE_PAR_A 2'h2
`define LCM_MODE_PAR_B 2'h3
`endif

// [logic/lcm_pkg.sv]
// types for the control-mode pin decoder
// assumes lcm_params.svh is visible on the include path
package lcm_pkg;
   typedef enum logic [3:0] {
      LCM_IF_HW = 4'h1,
      LCM_IF_SERIAL = 4'h2,
      LCM_IF_PAR_A = 4'h4,
      LCM_IF_PAR_B = 4'h8
   } lcm_if_e;
   typedef enum logic [1:0] {
      LCM_FMT_SINGLE_HDB3 = 2'h0,
      LCM_FMT_SINGLE_AMI = 2'h1,
      LCM_FMT_DUAL_CDR = 2'h2,
      LCM_FMT_SLICER = 2'h3
   } lcm_fmt_e;
   typedef enum logic [1:0] {
      LCM_LB_NONE = 2'h0,
      LCM_LB_ANALOG = 2'h1,
      LCM_LB_DIGITAL = 2'h2,
      LCM_LB_REMOTE = 2'h3
   } lcm_lb_e;
endpackage

// [logic/lcm_top.sv]
// control-mode pin decoder, host access gate, interrupt masking and status
// assumes pins are static straps synchronous to i_mclk; the line datapath is outside
`timescale 1ns/1ps
`default_nettype none
`include "lcm_params.svh"

// Behaviour
// - two select pins choose hardware, serial, parallel style A or style B control
// - hardware mode: edge pin low gives rising data update, high gives falling
// - hardware mode: format pins pick HDB3, AMI, dual rail CDR or slicer
// - hardware mode: loopback pins pick none, analog, digital or remote
// - inband loopback is never offered in hardware mode
// - host accesses answered only while active-low select is low
// - parallel port: select, 6-bit address, 8-bit data, strobe, direction, interrupt
// - all interrupt sources merge onto one interrupt output
// - global mask bit at one suppresses the interrupt output
// - two per-source mask registers at 13H and 14H
// - pending sources readable in status registers at 18H and 19H
// - interrupt output is push-pull with selectable active level
// - recovered clock carries data out on the edge chosen by the edge pin in hardware mode, on the rising edge in software modes
module lcm_top (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // strap pins
   input wire logic [1:0] i_if_select,
   input wire logic i_recv_clock_edge_select,
   input wire logic [1:0] i_line_format_select,
   input wire logic [1:0] i_ch1_loopback_select,
   // host port
   input wire logic i_cs_n,
   input wire logic [5:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_strobe_or_read,
   input wire logic i_dir_or_write,
   // interrupt sources, one-cycle pulses
   input wire logic [15:0] i_irq_event,
   // decoded configuration
   output logic [3:0] o_if_mode,
   output logic o_rx_falling_edge,
   output logic [1:0] o_line_format,
   output logic [1:0] o_ch1_loopback,
   output logic o_inband_lb_allowed,
   // host read data
   output logic [7:0] o_rdata,
   output logic o_rdata_oe,
   // interrupt pin
   output logic o_irq
);
   // --------------------------------------------------
   // strap decode
   // --------------------------------------------------
   function automatic lcm_pkg::lcm_if_e dec_mode(input logic [1:0] sel);
      case (sel)
         `LCM_MODE_HW: dec_mode = lcm_pkg::LCM_IF_HW;
         `LCM_MODE_SERIAL: dec_mode = lcm_pkg::LCM_IF_SERIAL;
         `LCM_MODE_PAR_A: dec_mode = lcm_pkg::LCM_IF_PAR_A;
         default: dec_mode = lcm_pkg::LCM_IF_PAR_B;
      endcase
   endfunction

   lcm_pkg::lcm_if_e if_mode;
   lcm_pkg::lcm_if_e next_if_mode;
   logic rx_falling_edge;
   logic next_rx_falling_edge;
   logic [1:0] line_format;
   logic [1:0] next_line_format;
   logic [1:0] ch1_loopback;
   logic [1:0] next_ch1_loopback;
   logic inband_ok;
   logic next_inband_ok;

   always_comb begin
      next_if_mode = dec_mode(i_if_select);
      if (next_if_mode == lcm_pkg::LCM_IF_HW) begin
         // in software modes the edge pin is grounded and ignored
         next_rx_falling_edge = i_recv_clock_edge_select;
         next_line_format = i_line_format_select;
         next_ch1_loopback = i_ch1_loopback_select;
         next_inband_ok = 1'b0;
      end else begin
         next_rx_falling_edge = 1'b0;
         next_line_format = lcm_pkg::LCM_FMT_SINGLE_HDB3;
         next_ch1_loopback = lcm_pkg::LCM_LB_NONE;
         next_inband_ok = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         if_mode <= lcm_pkg::LCM_IF_HW;
         rx_falling_edge <= 1'b0;
         line_format <= 2'h0;
         ch1_loopback <= 2'h0;
         inband_ok <= 1'b0;
      end else begin
         // straps are held stable by the board, so no filtering is spent here
         if_mode <= next_if_mode;
         rx_falling_edge <= next_rx_falling_edge;
         line_format <= next_line_format;
         ch1_loopback <= next_ch1_loopback;
         inband_ok <= next_inband_ok;
      end
   end

   // --------------------------------------------------
   // host register access
   // --------------------------------------------------
   logic host_en;
   logic wr_req;
   logic rd_req;
   assign host_en = (if_mode != lcm_pkg::LCM_IF_HW) && !i_cs_n;
   assign wr_req = host_en && i_strobe_or_read && !i_dir_or_write;
   assign rd_req = host_en && i_strobe_or_read && i_dir_or_write;

   logic [7:0] mask_first;
   logic [7:0] mask_second;
   logic [7:0] stat_first;
   logic [7:0] stat_second;
   logic [7:0] cfg;
   logic [7:0] next_mask_first;
   logic [7:0] next_mask_second;
   logic [7:0] next_stat_first;
   logic [7:0] next_stat_second;
   logic [7:0] next_cfg;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic rdata_oe;
   logic next_rdata_oe;

   always_comb begin
      next_mask_first = mask_first;
      next_mask_second = mask_second;
      next_cfg = cfg;
      // writing one to a status bit clears it; a new event in that cycle wins
      next_stat_first = stat_first;
      next_stat_second = stat_second;
      if (wr_req) begin
         case (i_addr)
            `LCM_OFS_MASK_FIRST: next_mask_first = i_wdata;
            `LCM_OFS_MASK_SECOND: next_mask_second = i_wdata;
            `LCM_OFS_STAT_FIRST: next_stat_first = stat_first & ~i_wdata;
            `LCM_OFS_STAT_SECOND: next_stat_second = stat_second & ~i_wdata;
            `LCM_OFS_GLOBAL_CFG: next_cfg = {6'h00, i_wdata[1:0]};
            default: next_cfg = cfg;
         endcase
      end
      next_stat_first = next_stat_first | i_irq_event[7:0];
      next_stat_second = next_stat_second | i_irq_event[15:8];
      next_rdata_oe = rd_req;
      case (i_addr)
         `LCM_OFS_MASK_FIRST: next_rdata = mask_first;
         `LCM_OFS_MASK_SECOND: next_rdata = mask_second;
         `LCM_OFS_STAT_FIRST: next_rdata = stat_first;
         `LCM_OFS_STAT_SECOND: next_rdata = stat_second;
         `LCM_OFS_GLOBAL_CFG: next_rdata = cfg;
         default: next_rdata = 8'h00;
      endcase
      if (!rd_req) begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         mask_first <= `LCM_MASK_RESET;
         mask_second <= `LCM_MASK_RESET;
         stat_first <= `LCM_STAT_RESET;
         stat_second <= `LCM_STAT_RESET;
         cfg <= `LCM_CFG_RESET;
         rdata <= 8'h00;
         rdata_oe <= 1'b0;
      end else begin
         mask_first <= next_mask_first;
         mask_second <= next_mask_second;
         stat_first <= next_stat_first;
         stat_second <= next_stat_second;
         cfg <= next_cfg;
         rdata <= next_rdata;
         rdata_oe <= next_rdata_oe;
      end
   end

   // --------------------------------------------------
   // interrupt output
   // --------------------------------------------------
   logic irq_any;
   logic irq;
   logic next_irq;
   assign irq_any = |(stat_first & ~mask_first) | |(stat_second & ~mask_second);

   always_comb begin
      // pin is push-pull; the level is inverted when active-low is chosen
      next_irq = (irq_any && !cfg[`LCM_CFG_BIT_GMASK]) ^ !cfg[`LCM_CFG_BIT_IRQ_POL];
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq <= 1'b1;
      end else begin
         irq <= next_irq;
      end
   end

   assign o_if_mode = if_mode;
   assign o_rx_falling_edge = rx_falling_edge;
   assign o_line_format = line_format;
   assign o_ch1_loopback = ch1_loopback;
   assign o_inband_lb_allowed = inband_ok;
   assign o_rdata = rdata;
   assign o_rdata_oe = rdata_oe;
   assign o_irq = irq;

   // --------------------------------------------------
   // checks
   // --------------------------------------------------
   sequence seq_wr_mask(logic [5:0] ofs);
      wr_req && i_addr == ofs;
   endsequence

   // a read of one register, answered on the following edge
   sequence seq_rd_reg(logic [5:0] ofs);
      rd_req && i_addr == ofs;
   endsequence

   // a write that no register claims; it must leave every register alone
   sequence seq_wr_unmapped;
      wr_req && !(i_addr inside {`LCM_OFS_MASK_FIRST, `LCM_OFS_MASK_SECOND,
         `LCM_OFS_STAT_FIRST, `LCM_OFS_STAT_SECOND, `LCM_OFS_GLOBAL_CFG});
   endsequence

   // a selected strobe while the straps choose hardware control
   sequence seq_hw_strobe;
      if_mode == lcm_pkg::LCM_IF_HW && !i_cs_n && i_strobe_or_read;
   endsequence

   AST_MODE_DECODE: assert property (@(posedge i_mclk) disable iff (i_rst)
      1'b1 |=> o_if_mode == (4'h1 << $past(i_if_select)))
      else $error("interface mode decode wrong");
   AST_EDGE_SEL: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_if_select == 2'h0 |=> o_rx_falling_edge == $past(i_recv_clock_edge_select))
      else $error("receive edge select not followed");
   AST_FORMAT: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_if_select == 2'h0 |=> o_line_format == $past(i_line_format_select))
      else $error("line format not followed");
   AST_LOOPBACK: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_if_select == 2'h0 |=> o_ch1_loopback == $past(i_ch1_loopback_select))
      else $error("loopback select not followed");
   AST_NO_INBAND: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_if_mode == 4'h1 |-> !o_inband_lb_allowed)
      else $error("inband loopback offered in hardware mode");
   AST_CS_GATE: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_cs_n |=> !o_rdata_oe)
      else $error("read answered without select");
   AST_MASK_WRITE: assert property (@(posedge i_mclk) disable iff (i_rst)
      seq_wr_mask(`LCM_OFS_MASK_FIRST) |=> mask_first == $past(i_wdata))
      else $error("mask write lost");
   AST_STATUS_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_irq_event[0] |=> stat_first[0])
      else $error("event not recorded");
   AST_GLOBAL_MASK: assert property (@(posedge i_mclk) disable iff (i_rst)
      cfg[`LCM_CFG_BIT_GMASK] && $stable(cfg) |=> o_irq == !$past(cfg[`LCM_CFG_BIT_IRQ_POL]))
      else $error("interrupt not suppressed");
   AST_IRQ_MERGE: assert property (@(posedge i_mclk) disable iff (i_rst)
      irq_any && !cfg[`LCM_CFG_BIT_GMASK] |=> o_irq == $past(cfg[`LCM_CFG_BIT_IRQ_POL]))
      else $error("pending source not signalled");

   // host port, status register, software-mode strap and idle interrupt checks
   AST_MASK2_WRITE: assert property (@(posedge i_mclk) disable iff (i_rst)
      seq_wr_mask(`LCM_OFS_MASK_SECOND) |=> mask_second == $past(i_wdata))
      else $error("second mask write lost");
   AST_STATUS_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
      seq_wr_mask(`LCM_OFS_STAT_SECOND) |=>
      stat_second == (($past(stat_second) & ~$past(i_wdata)) | $past(i_irq_event[15:8])))
      else $error("status clear wrong or new event lost");
   AST_STATUS_STICKY: assert property (@(posedge i_mclk) disable iff (i_rst)
      stat_second[0] && !(wr_req && i_addr == `LCM_OFS_STAT_SECOND && i_wdata[0])
      |=> stat_second[0])
      else $error("pending status bit dropped");
   AST_STATUS_READ: assert property (@(posedge i_mclk) disable iff (i_rst)
      seq_rd_reg(`LCM_OFS_STAT_FIRST) |=> o_rdata_oe && o_rdata == $past(stat_first))
      else $error("status read wrong");
   AST_READ_ANSWER: assert property (@(posedge i_mclk) disable iff (i_rst)
      rd_req |=> o_rdata_oe)
      else $error("selected read not answered");
   AST_RDATA_QUIET: assert property (@(posedge i_mclk) disable iff (i_rst)
      !o_rdata_oe |-> o_rdata == 8'h00)
      else $error("read data shown without enable");
   AST_HW_NO_READ: assert property (@(posedge i_mclk) disable iff (i_rst)
      seq_hw_strobe |=> !o_rdata_oe)
      else $error("host read answered in hardware mode");
   AST_HW_NO_WRITE: assert property (@(posedge i_mclk) disable iff (i_rst)
      seq_hw_strobe |=> $stable(cfg) && $stable(mask_first) && $stable(mask_second))
      else $error("host write taken in hardware mode");
   AST_UNMAPPED_WRITE: assert property (@(posedge i_mclk) disable iff (i_rst)
      seq_wr_unmapped |=> $stable(cfg) && $stable(mask_first) && $stable(mask_second))
      else $error("unmapped write changed a register");
   AST_SW_EDGE_OFF: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_if_select != 2'h0 |=> !o_rx_falling_edge && o_inband_lb_allowed)
      else $error("edge select used outside hardware mode");
   AST_IRQ_IDLE: assert property (@(posedge i_mclk) disable iff (i_rst)
      !irq_any |=> o_irq == !$past(cfg[`LCM_CFG_BIT_IRQ_POL]))
      else $error("interrupt raised with no pending source");
endmodule
`default_nettype wire

// [verification/lcm_strap_board.sv]
// board strap model for the control-mode decoder
// assumes the bench changes a request only while no host access runs
`timescale 1ns/1ps
`default_nettype none
module lcm_strap_board (
   // requested strap levels
   input wire logic [1:0] i_mode,
   input wire logic i_edge,
   input wire logic [1:0] i_fmt,
   input wire logic [1:0] i_lb,
   // strap pins
   output logic [1:0] o_if_select,
   output logic o_edge_pin,
   output logic [1:0] o_fmt_pin,
   output logic [1:0] o_lb_pin
);
   // edge pin is grounded outside hardware mode, where it has no function
   assign o_edge_pin = (i_mode == 2'h0) ? i_edge : 1'b0;
   // straps are levels only, never pulsed
   assign o_if_select = i_mode;
   assign o_fmt_pin = i_fmt;
   assign o_lb_pin = i_lb;
endmodule
`default_nettype wire

// [verification/lcm_top_tb_top.sv]
// self-checking bench for the control-mode decoder and its interrupt registers
// assumes lcm_strap_board stands in for the board; the bench acts as host
`timescale 1ns/1ps
`default_nettype none
module lcm_top_tb_top;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [1:0] mode = 2'h0, fmt = 2'h0, lb = 2'h0, if_sel, fmt_pin, lb_pin, lfmt, lbk;
   logic edge_rq = 1'b0, edge_pin, cs_n = 1'b1, stb = 1'b0, dir = 1'b0, fall, inb, oe, irq;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00, rdata, m, b;
   logic [15:0] ev = 16'h0000;
   logic [3:0] if_mode;
   logic [7:0] expq [$];
   int mismatches = 0, tests_run = 0, k;
   lcm_strap_board brd (.i_mode(mode), .i_edge(edge_rq), .i_fmt(fmt), .i_lb(lb),
      .o_if_select(if_sel), .o_edge_pin(edge_pin), .o_fmt_pin(fmt_pin), .o_lb_pin(lb_pin));
   lcm_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_if_select(if_sel),
      .i_recv_clock_edge_select(edge_pin), .i_line_format_select(fmt_pin),
      .i_ch1_loopback_select(lb_pin), .i_cs_n(cs_n), .i_addr(addr), .i_wdata(wdata),
      .i_strobe_or_read(stb), .i_dir_or_write(dir), .i_irq_event(ev), .o_if_mode(if_mode),
      .o_rx_falling_edge(fall), .o_line_format(lfmt), .o_ch1_loopback(lbk),
      .o_inband_lb_allowed(inb), .o_rdata(rdata), .o_rdata_oe(oe), .o_irq(irq));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: pins %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] got);
      tests_run++;
      if (expq.size() == 0) begin
         mismatches++;
         $display("wrong value at %0t: unexpected read answer", $time);
      end else if (got !== expq[0]) begin
         mismatches++;
         $display("wrong value at %0t: read %h expected %h", $time, got, expq[0]);
      end
      if (expq.size() != 0) expq.pop_front();
   endtask
   // released address and data lines are inverted so stale values never look valid
   task automatic acc(input logic is_rd, input logic csn, input logic [5:0] a, input logic [7:0] d);
      @(posedge i_mclk) #1;
      cs_n = csn;
      stb = 1'b1;
      dir = is_rd;
      addr = a;
      wdata = d;
      @(posedge i_mclk) #1;
      cs_n = 1'b1;
      stb = 1'b0;
      addr = ~addr;
      wdata = ~wdata;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      expq.push_back(e);
      acc(1'b1, 1'b0, a, 8'h00);
   endtask
   task automatic pulse(input int bit_no);
      @(posedge i_mclk) #1;
      ev[bit_no] = 1'b1;
      @(posedge i_mclk) #1;
      ev = 16'h0000;
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge i_mclk);
      #1 cmp_pin({7'h00, irq}, {7'h00, e});
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock, watcher, watchdog and main sequence
   // ----------------------------------------
   initial begin
      forever #5 i_mclk = ~i_mclk;
   end
   // read data stands one cycle, so it is looked at mid-cycle
   always @(negedge i_mclk) begin
      if (oe === 1'b1) cmp_rd(rdata);
   end
   initial begin
      #200000;
      mismatches++;
      $display("wrong value at %0t: run timed out", $time);
      final_report();
   end
   initial begin
      k = $urandom(48707);
      repeat (20) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      irq_is(1'b1);
      for (int c = 0; c < 32; c++) begin
         {edge_rq, fmt, lb} = c[4:0];
         repeat (3) @(posedge i_mclk);
         #1 cmp_pin({if_mode, fall, inb, 2'h0}, {4'h1, c[4], 1'b0, 2'h0});
         cmp_pin({4'h0, lfmt, lbk}, {4'h0, c[3:0]});
      end
      acc(1'b1, 1'b0, 6'h13, 8'h00);
      acc(1'b0, 1'b0, 6'h20, 8'h00);
      $display("test hardware straps done");
      for (int c = 1; c < 4; c++) begin
         mode = c[1:0];
         repeat (3) @(posedge i_mclk);
         #1 cmp_pin({if_mode, fall, inb, 2'h0}, {4'h1 << c, 1'b0, 1'b1, 2'h0});
         cmp_pin({4'h0, lfmt, lbk}, 8'h00);
      end
      $display("test software modes done");
      acc(1'b0, 1'b0, 6'h3F, 8'h00);
      rd(6'h13, 8'hFF);
      rd(6'h14, 8'hFF);
      rd(6'h18, 8'h00);
      rd(6'h19, 8'h00);
      rd(6'h20, 8'h01);
      rd(6'h3F, 8'h00);
      m = 8'($urandom);
      acc(1'b0, 1'b0, 6'h14, m);
      acc(1'b0, 1'b1, 6'h14, ~m);
      rd(6'h14, m);
      $display("test registers done");
      k = $urandom % 8;
      b = 8'h01 << k;
      acc(1'b0, 1'b0, 6'h13, ~b);
      acc(1'b0, 1'b0, 6'h14, 8'hFF);
      acc(1'b0, 1'b0, 6'h20, 8'h00);
      pulse(k);
      irq_is(1'b0);
      rd(6'h18, b);
      acc(1'b0, 1'b0, 6'h20, 8'h01);
      irq_is(1'b1);
      acc(1'b0, 1'b0, 6'h20, 8'h02);
      irq_is(1'b1);
      acc(1'b0, 1'b0, 6'h18, b);
      irq_is(1'b0);
      pulse(k + 8);
      irq_is(1'b0);
      rd(6'h19, b);
      acc(1'b0, 1'b0, 6'h14, ~b);
      irq_is(1'b1);
      acc(1'b0, 1'b0, 6'h19, b);
      irq_is(1'b0);
      rd(6'h19, 8'h00);
      $display("test interrupts done");
      repeat (3) @(posedge i_mclk);
      if (expq.size() != 0) begin
         mismatches++;
         $display("wrong value at %0t: read answers missing", $time);
      end
      final_report();
   end
endmodule
`default_nettype wire
